// ### logic/pointer_mask_pkg.sv
package pointer_mask_pkg;

	localparam int DATA_W = 64;
	localparam int ADDR_W = 4;

	// Register word indices on the plain register port
	localparam logic [3:0] OFS_SUP_ENV   = 4'h0;
	localparam logic [3:0] OFS_HYP_ENV   = 4'h1;
	localparam logic [3:0] OFS_HYP_STAT  = 4'h2;
	localparam logic [3:0] OFS_MACH_ENV  = 4'h3;
	localparam logic [3:0] OFS_MACH_SEC  = 4'h4;
	localparam logic [3:0] OFS_WIDTH     = 4'h5;
	localparam logic [3:0] OFS_EFFECTIVE = 4'h6;

	// Field positions (low bit of each field; mode and width fields are two bits)
	localparam int POS_MASK_MODE  = 32;
	localparam int POS_HYP_USER   = 48;
	localparam int POS_USER_WIDTH = 0;
	localparam int POS_SUP_WIDTH  = 2;
	localparam int POS_MACH_WIDTH = 4;
	localparam int POS_EFF_COUNT  = 0;
	localparam int POS_EFF_SRC    = 8;

	// Mask mode encodings
	localparam logic [1:0] MODE_OFF  = 2'h0;
	localparam logic [1:0] MODE_RSVD = 2'h1;
	localparam logic [1:0] MODE_M57  = 2'h2;
	localparam logic [1:0] MODE_M48  = 2'h3;

	// Width selector encodings and reset values
	localparam logic [1:0] WIDTH_32 = 2'h1;
	localparam logic [1:0] WIDTH_64 = 2'h2;
	localparam logic [1:0] RST_MASK_MODE = 2'h0;

	// Masked bit counts on a 64-bit hart
	localparam logic [4:0] MASKED_BITS_57 = 5'h07;
	localparam logic [4:0] MASKED_BITS_48 = 5'h10;

	// Privilege encodings
	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;

	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_SUP_ENV,
		SRC_HYP_ENV,
		SRC_HYP_USER,
		SRC_MACH_ENV,
		SRC_MACH_SEC
	} mask_src_t;

endpackage

// ### logic/pointer_mask_config.sv
// Function
// - Mask field 00 off, 01 reserved, 10 masks 7 bits, 11 masks 16.
// - On a 32-bit hart all mask fields read zero.
// - On a 32-bit hart enabling writes are illegal and change nothing.
// - Width selector at 32 bits makes enabling writes for that mode ignored.
// - Mask field bit positions stay the same on 32-bit harts.
// - Writing width selector 32 bits clears that mode's mask fields.
// - Returning width to 64 bits does not restore cleared fields.
// - Supervisor env field at 33:32 governs user and virtual user mode.
// - Hypervisor env field at 33:32 governs virtual supervisor mode.
// - Hypervisor status 49:48 governs hyp loads/stores from user as VU.
// - Hyp loads/stores as VU from HS or M use supervisor env field.
// - Hyp loads/stores as VS use hypervisor env field.
// - Hyp exec-permission loads are never masked.
// - No masking while make-executable-readable is in effect.
// - Machine env field governs supervisor, or user if no supervisor.
// - Virtual modes with bare guest translation zero-extend as physical.
// - Machine security field at 33:32 governs machine mode.
// - Machine security register exists whenever machine masking exists.
// - Field changes act on the next access with no fence.
// - Setting of the currently active privilege mode applies.
// - Modify-privilege and previous-virtual controls select effective mode.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pointer_mask_config
	import pointer_mask_pkg::*;
#(
	parameter int XLEN     = 64,
	parameter bit HAS_SUP  = 1'b1,
	parameter bit HAS_HYP  = 1'b1,
	parameter bit HAS_MACH = 1'b1
) (
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdata,
	input  wire logic              accValid,
	input  wire logic [XLEN-1:0]   accAddr,
	input  wire logic [1:0]        curPriv,
	input  wire logic              curVirt,
	input  wire logic              modify_privilege_flag,
	input  wire logic [1:0]        prevPriv,
	input  wire logic              prevVirt,
	input  wire logic              sup_prev_virt_priv,
	input  wire logic              make_exec_readable,
	input  wire logic              hyp_virt_load,
	input  wire logic              hyp_virt_store,
	input  wire logic              hyp_virt_exec_load,
	input  wire logic              supTransBare,
	input  wire logic              guestTransBare,
	output logic                   outValid,
	output logic      [XLEN-1:0]   outAddr,
	output logic      [4:0]        masked_bit_count
);

	// Elaboration checks refuse layouts the logic cannot serve
	if (XLEN != 64 && XLEN != 32) begin : g_bad_xlen
		$error("pointer_mask_config: XLEN must be 32 or 64");
	end
	if (HAS_HYP && !HAS_SUP) begin : g_bad_hyp
		$error("pointer_mask_config: hypervisor needs supervisor");
	end
	// Hypervisor user field is the highest one in the word
	if (DATA_W < POS_HYP_USER + 2) begin : g_bad_data_w
		$error("pointer_mask_config: register word too narrow");
	end
	if (ADDR_W < 3) begin : g_bad_addr_w
		$error("pointer_mask_config: register index too narrow");
	end

	localparam bit WIDE = (XLEN == 64);
	localparam logic [1:0] RST_WIDTH = WIDE ? WIDTH_64 : WIDTH_32;

	typedef struct packed {
		logic [1:0]        supEnvMode;
		logic [1:0]        hypEnvMode;
		logic [1:0]        hyp_user_mask_mode;
		logic [1:0]        machEnvMode;
		logic [1:0]        machSecMode;
		logic [1:0]        user_width_selector;
		logic [1:0]        sup_width_selector;
		logic [1:0]        mach_width_selector;
		logic [DATA_W-1:0] rdata;
		logic              valid;
		logic [XLEN-1:0]   addr;
		logic [4:0]        count;
	} state_t;

	state_t state_r;
	state_t state_nxt;

	// Legal-value filter for a mask field write
	// Illegal writes keep the old field; zeroing would lose settings
	function automatic logic [1:0] filterMode(
		input logic [1:0] oldVal,
		input logic [1:0] newVal,
		input logic [1:0] width
	);
		logic [1:0] res;
		res = newVal;
		if (!WIDE)
			res = MODE_OFF;
		else if (newVal == MODE_RSVD)
			res = oldVal;
		else if (width == WIDTH_32 && newVal != MODE_OFF)
			res = oldVal;
		return res;
	endfunction

	function automatic logic [4:0] modeCount(input logic [1:0] mode);
		logic [4:0] res;
		case (mode)
			MODE_M57: res = MASKED_BITS_57;
			MODE_M48: res = MASKED_BITS_48;
			default:  res = 5'h00;
		endcase
		return WIDE ? res : 5'h00;
	endfunction

	function automatic logic [1:0] legalWidth(
		input logic [1:0] oldVal,
		input logic [1:0] newVal
	);
		logic [1:0] res;
		res = oldVal;
		if (WIDE && (newVal == WIDTH_32 || newVal == WIDTH_64))
			res = newVal;
		return res;
	endfunction

	// Field placed at the same bit position on either hart width
	function automatic logic [DATA_W-1:0] place(
		input logic [1:0] val,
		input int         pos
	);
		logic [DATA_W-1:0] res;
		res = '0;
		res[pos +: 2] = WIDE ? val : MODE_OFF;
		return res;
	endfunction

	logic [1:0] machGovWidth;
	logic [1:0] effPriv;
	logic       effVirt;
	logic       hypAcc;
	logic       isVirtual;
	logic [1:0] selMode;
	mask_src_t  selSrc;

	// Machine env field follows the width of the mode that it governs
	assign machGovWidth = HAS_SUP ? state_r.sup_width_selector
	                              : state_r.user_width_selector;
	assign hypAcc = HAS_HYP && (hyp_virt_load || hyp_virt_store);

	// Hypervisor virtual accesses always act as a guest mode
	always_comb begin
		effPriv = curPriv;
		effVirt = curVirt;
		if (hypAcc) begin
			effVirt = 1'b1;
			effPriv = sup_prev_virt_priv ? PRIV_S : PRIV_U;
		end else if (modify_privilege_flag && curPriv == PRIV_M) begin
			effPriv = prevPriv;
			effVirt = HAS_HYP && prevVirt && prevPriv != PRIV_M;
		end
	end

	// Exempt accesses first, then hypervisor forms, then plain modes
	always_comb begin
		selSrc = SRC_NONE;
		if (hyp_virt_exec_load) begin
			selSrc = SRC_NONE;
		end else if (make_exec_readable) begin
			selSrc = SRC_NONE;
		end else if (hypAcc && effPriv == PRIV_U) begin
			if (curPriv == PRIV_U && !curVirt)
				selSrc = SRC_HYP_USER;
			else
				selSrc = SRC_SUP_ENV;
		end else if (effPriv == PRIV_M) begin
			selSrc = HAS_MACH ? SRC_MACH_SEC : SRC_NONE;
		end else if (effVirt && HAS_HYP) begin
			if (effPriv == PRIV_S)
				selSrc = SRC_HYP_ENV;
			else
				selSrc = SRC_SUP_ENV;
		end else if (effPriv == PRIV_S) begin
			selSrc = SRC_MACH_ENV;
		end else begin
			selSrc = HAS_SUP ? SRC_SUP_ENV : SRC_MACH_ENV;
		end
	end

	// Live field values feed the next access directly
	always_comb begin
		case (selSrc)
			SRC_SUP_ENV:  selMode = state_r.supEnvMode;
			SRC_HYP_ENV:  selMode = state_r.hypEnvMode;
			SRC_HYP_USER: selMode = state_r.hyp_user_mask_mode;
			SRC_MACH_ENV: selMode = state_r.machEnvMode;
			SRC_MACH_SEC: selMode = state_r.machSecMode;
			default:      selMode = MODE_OFF;
		endcase
	end

	// Machine mode never translates, so its addresses are physical
	always_comb begin
		if (effPriv == PRIV_M)
			isVirtual = 1'b0;
		else if (effVirt && HAS_HYP)
			isVirtual = !guestTransBare;
		else
			isVirtual = !supTransBare;
	end

	always_comb begin
		logic [4:0]      cnt;
		logic [XLEN-1:0] keepMask;
		logic            topBit;
		int              msbIdx;
		cnt = 5'h00;
		keepMask = '1;
		topBit = 1'b0;
		msbIdx = 0;
		state_nxt = state_r;

		// Register writes
		if (regWr) begin
			case (regAddr)
				OFS_SUP_ENV: begin
					state_nxt.supEnvMode = filterMode(state_r.supEnvMode,
						regWdata[POS_MASK_MODE +: 2],
						state_r.user_width_selector);
				end
				OFS_HYP_ENV: begin
					if (HAS_HYP)
						state_nxt.hypEnvMode = filterMode(state_r.hypEnvMode,
							regWdata[POS_MASK_MODE +: 2],
							state_r.sup_width_selector);
				end
				OFS_HYP_STAT: begin
					if (HAS_HYP)
						state_nxt.hyp_user_mask_mode = filterMode(
							state_r.hyp_user_mask_mode,
							regWdata[POS_HYP_USER +: 2],
							state_r.user_width_selector);
				end
				OFS_MACH_ENV: begin
					state_nxt.machEnvMode = filterMode(state_r.machEnvMode,
						regWdata[POS_MASK_MODE +: 2], machGovWidth);
				end
				OFS_MACH_SEC: begin
					if (HAS_MACH)
						state_nxt.machSecMode = filterMode(
							state_r.machSecMode,
							regWdata[POS_MASK_MODE +: 2],
							state_r.mach_width_selector);
				end
				OFS_WIDTH: begin
					state_nxt.user_width_selector = legalWidth(
						state_r.user_width_selector,
						regWdata[POS_USER_WIDTH +: 2]);
					state_nxt.sup_width_selector = legalWidth(
						state_r.sup_width_selector,
						regWdata[POS_SUP_WIDTH +: 2]);
					state_nxt.mach_width_selector = legalWidth(
						state_r.mach_width_selector,
						regWdata[POS_MACH_WIDTH +: 2]);
				end
				default: begin
				end
			endcase
		end

		// Narrowing a mode drops its fields for good; nothing is shadowed
		if (regWr && regAddr == OFS_WIDTH) begin
			if (regWdata[POS_USER_WIDTH +: 2] == WIDTH_32) begin
				state_nxt.supEnvMode = MODE_OFF;
				state_nxt.hyp_user_mask_mode = MODE_OFF;
				if (!HAS_SUP)
					state_nxt.machEnvMode = MODE_OFF;
			end
			if (regWdata[POS_SUP_WIDTH +: 2] == WIDTH_32) begin
				state_nxt.hypEnvMode = MODE_OFF;
				if (HAS_SUP)
					state_nxt.machEnvMode = MODE_OFF;
			end
			if (regWdata[POS_MACH_WIDTH +: 2] == WIDTH_32)
				state_nxt.machSecMode = MODE_OFF;
		end

		// Register reads; unmapped indices answer zero
		state_nxt.rdata = '0;
		if (regRd) begin
			case (regAddr)
				OFS_SUP_ENV:
					state_nxt.rdata = place(state_r.supEnvMode,
						POS_MASK_MODE);
				OFS_HYP_ENV:
					state_nxt.rdata = place(state_r.hypEnvMode,
						POS_MASK_MODE);
				OFS_HYP_STAT:
					state_nxt.rdata = place(state_r.hyp_user_mask_mode,
						POS_HYP_USER);
				OFS_MACH_ENV:
					state_nxt.rdata = place(state_r.machEnvMode,
						POS_MASK_MODE);
				OFS_MACH_SEC:
					state_nxt.rdata = place(state_r.machSecMode,
						POS_MASK_MODE);
				OFS_WIDTH: begin
					state_nxt.rdata[POS_USER_WIDTH +: 2] =
						state_r.user_width_selector;
					state_nxt.rdata[POS_SUP_WIDTH +: 2] =
						state_r.sup_width_selector;
					state_nxt.rdata[POS_MACH_WIDTH +: 2] =
						state_r.mach_width_selector;
				end
				OFS_EFFECTIVE: begin
					state_nxt.rdata[POS_EFF_COUNT +: 5] = state_r.count;
					state_nxt.rdata[POS_EFF_SRC +: 3] = selSrc;
				end
				default: state_nxt.rdata = '0;
			endcase
		end

		// Address transform, one cycle of latency
		// Sign fill only for translated addresses; physical ones zero-fill
		cnt = modeCount(selMode);
		keepMask = {XLEN{1'b1}} >> cnt;
		msbIdx = XLEN - 1 - int'(cnt);
		topBit = accAddr[msbIdx];
		state_nxt.valid = accValid;
		if (accValid) begin
			state_nxt.count = cnt;
			if (isVirtual && topBit)
				state_nxt.addr = accAddr | ~keepMask;
			else
				state_nxt.addr = accAddr & keepMask;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r.supEnvMode <= RST_MASK_MODE;
			state_r.hypEnvMode <= RST_MASK_MODE;
			state_r.hyp_user_mask_mode <= RST_MASK_MODE;
			state_r.machEnvMode <= RST_MASK_MODE;
			state_r.machSecMode <= RST_MASK_MODE;
			state_r.user_width_selector <= RST_WIDTH;
			state_r.sup_width_selector <= RST_WIDTH;
			state_r.mach_width_selector <= RST_WIDTH;
			state_r.rdata <= '0;
			state_r.valid <= 1'b0;
			state_r.addr <= '0;
			state_r.count <= 5'h00;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign regRdata = state_r.rdata;
	assign outValid = state_r.valid;
	assign outAddr = state_r.addr;
	assign masked_bit_count = state_r.count;

endmodule
`default_nettype wire

// ### tb/pointer_mask_config_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pointer_mask_config_asserts
	import pointer_mask_pkg::*;
#(
	parameter int XLEN = 64
) (
	input wire logic              sys_clk,
	input wire logic              nrst,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic              regRd,
	input wire logic [DATA_W-1:0] regRdata,
	input wire logic              accValid,
	input wire logic [XLEN-1:0]   accAddr,
	input wire logic              make_exec_readable,
	input wire logic              hyp_virt_exec_load,
	input wire logic              outValid,
	input wire logic [XLEN-1:0]   outAddr,
	input wire logic [4:0]        masked_bit_count
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	chk_valid_follows: assert property (
		outValid == $past(accValid))
		else $error("outValid does not follow accValid");
	chk_count_legal: assert property (
		outValid |-> masked_bit_count inside {5'h00, 5'h07, 5'h10})
		else $error("illegal masked bit count");
	chk_exec_unmasked: assert property (
		$past(accValid && hyp_virt_exec_load) |->
			masked_bit_count == 5'h00 && outAddr == $past(accAddr))
		else $error("exec-permission load was masked");
	chk_readable_unmasked: assert property (
		$past(accValid && make_exec_readable) |->
			masked_bit_count == 5'h00 && outAddr == $past(accAddr))
		else $error("access masked while exec-readable set");
	chk_keep_16: assert property (
		outValid && masked_bit_count == MASKED_BITS_48 |->
			outAddr[XLEN-17:0] == $past(accAddr[XLEN-17:0]) &&
			(outAddr[XLEN-1:XLEN-16] == 16'h0000 ||
			 outAddr[XLEN-1:XLEN-16] == {16{outAddr[XLEN-17]}}))
		else $error("16-bit mask result wrong");
	chk_keep_7: assert property (
		outValid && masked_bit_count == MASKED_BITS_57 |->
			outAddr[XLEN-8:0] == $past(accAddr[XLEN-8:0]) &&
			(outAddr[XLEN-1:XLEN-7] == 7'h00 ||
			 outAddr[XLEN-1:XLEN-7] == {7{outAddr[XLEN-8]}}))
		else $error("7-bit mask result wrong");
	chk_keep_zero: assert property (
		outValid && masked_bit_count == 5'h00 |-> outAddr == $past(accAddr))
		else $error("unmasked access altered");
	chk_mode_legal: assert property (
		$past(regRd) && $past(regAddr) < OFS_WIDTH &&
			$past(regAddr) != OFS_HYP_STAT |->
			regRdata[33:32] != MODE_RSVD)
		else $error("reserved mask mode stored");
endmodule
bind pointer_mask_config pointer_mask_config_asserts #(.XLEN(XLEN)) i_chk (
	.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr), .regRd(regRd),
	.regRdata(regRdata), .accValid(accValid), .accAddr(accAddr),
	.make_exec_readable(make_exec_readable),
	.hyp_virt_exec_load(hyp_virt_exec_load), .outValid(outValid),
	.outAddr(outAddr), .masked_bit_count(masked_bit_count));
`default_nettype wire

// ### tb/pointer_mask_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pointer_mask_config_tb_top;
	import pointer_mask_pkg::*;
	// Row: previous priv, previous virt, sup bare, priv, virt, hyp
	// access, as-VS, exec-readable, exec load, guest bare,
	// modify-privilege, then expected source and physical flag
	localparam logic [16:0] TAB [17] = '{17'h00002, 17'h00808,
		17'h0180B, 17'h00402, 17'h00C25, 17'h01812, 17'h00206,
		17'h00A02, 17'h00B04, 17'h00080, 17'h00240, 17'h00423,
		17'h0D814, 17'h1981B, 17'h02003, 17'h02809, 17'h18818};
	logic        sys_clk, nrst, regWr, regRd, accValid, outValid;
	logic        curVirt, mpv, svp, xrd, hvl, hvs, exl, gb;
	logic        pv, stb, ov32;
	logic [1:0]  curPriv, pp;
	logic [3:0]  regAddr;
	logic [63:0] regWdata, regRdata, accAddr, outAddr, rd32;
	logic [31:0] oa32;
	logic [4:0]  cnt, cnt32;
	logic [1:0]  mf [5];
	logic [5:0]  wid;
	int          failures, n_tests, seed, cyc;

	pointer_mask_config i_dut (
		.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .accValid(accValid), .accAddr(accAddr),
		.curPriv(curPriv), .curVirt(curVirt), .modify_privilege_flag(mpv),
		.prevPriv(pp), .prevVirt(pv), .sup_prev_virt_priv(svp),
		.make_exec_readable(xrd), .hyp_virt_load(hvl),
		.hyp_virt_store(hvs), .hyp_virt_exec_load(exl),
		.supTransBare(stb), .guestTransBare(gb), .outValid(outValid),
		.outAddr(outAddr), .masked_bit_count(cnt));

	// Narrow hart on the same bus and access inputs
	pointer_mask_config #(.XLEN(32)) i_dut32 (
		.sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(rd32), .accValid(accValid), .accAddr(accAddr[31:0]),
		.curPriv(curPriv), .curVirt(curVirt), .modify_privilege_flag(mpv),
		.prevPriv(pp), .prevVirt(pv), .sup_prev_virt_priv(svp),
		.make_exec_readable(xrd), .hyp_virt_load(hvl),
		.hyp_virt_store(hvs), .hyp_virt_exec_load(exl),
		.supTransBare(stb), .guestTransBare(gb), .outValid(ov32),
		.outAddr(oa32), .masked_bit_count(cnt32));

	always #12.5 sys_clk = ~sys_clk;

	function automatic int pos(input int i);
		return i == OFS_HYP_STAT ? POS_HYP_USER : POS_MASK_MODE;
	endfunction
	// Width group owning each field: user, supervisor, machine
	function automatic int grp(input int i);
		return (i == 0 || i == 2) ? 0 : (i == 4 ? 2 : 1);
	endfunction
	function automatic logic [63:0] exp_rd(input int a);
		if (a == OFS_WIDTH) return {58'h0, wid};
		if (a > OFS_MACH_SEC) return 64'h0;
		return {62'h0, mf[a]} << pos(a);
	endfunction

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input int a, input logic [63:0] d);
		logic [1:0] v;
		@(posedge sys_clk);
		regWr <= 1'b1;
		regAddr <= a[3:0];
		regWdata <= d;
		@(posedge sys_clk);
		regWr <= 1'b0;
		if (a < OFS_WIDTH) begin
			v = d[pos(a) +: 2];
			if (v == MODE_OFF || (v != MODE_RSVD &&
				wid[2*grp(a) +: 2] != WIDTH_32)) mf[a] = v;
		end else if (a == OFS_WIDTH) begin
			for (int k = 0; k < 3; k++) begin
				v = d[2*k +: 2];
				if (v == WIDTH_32 || v == WIDTH_64) wid[2*k +: 2] = v;
				for (int j = 0; j < 5; j++)
					if (v == WIDTH_32 && grp(j) == k) mf[j] = MODE_OFF;
			end
		end
	endtask
	// Narrow hart: fields read zero, widths stay 32-bit, count zero
	task automatic rd(input int a, input logic [63:0] e);
		logic [63:0] e32;
		e32 = a == OFS_WIDTH ? {58'h0, {3{WIDTH_32}}} : 64'h0;
		if (a == OFS_EFFECTIVE) e32 = e & ~64'h1F;
		@(posedge sys_clk);
		regRd <= 1'b1;
		regAddr <= a[3:0];
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk("regRdata", regRdata, e);
		chk("regRdata32", rd32, e32);
	endtask
	task automatic fw(input int i, input logic [1:0] m);
		logic [63:0] d;
		d = {$random(seed), $random(seed)};
		d[pos(i) +: 2] = m;
		wr(i, d);
	endtask
	task automatic acc(input logic [16:0] t, input logic ld);
		logic [63:0] a, e;
		logic [1:0]  m;
		int          c;
		a = {$random(seed), $random(seed)};
		@(posedge sys_clk);
		accValid <= 1'b1;
		accAddr <= a;
		{pp, pv, stb} <= t[16:13];
		{curPriv, curVirt} <= t[12:10];
		hvl <= t[9] & ld;
		hvs <= t[9] & !ld;
		{svp, xrd, exl, gb, mpv} <= t[8:4];
		@(posedge sys_clk);
		accValid <= 1'b0;
		#1;
		m = t[3:1] == 3'h0 ? MODE_OFF : mf[t[3:1] - 3'h1];
		c = m == MODE_M48 ? 16 : (m == MODE_M57 ? 7 : 0);
		e = a << c;
		// Physical addresses zero-extend, virtual ones sign-extend
		if (t[0]) e = e >> c;
		else e = $signed(e) >>> c;
		chk("outValid", {63'h0, outValid}, 64'h1);
		chk("count", {59'h0, cnt}, 64'(c));
		chk("outAddr", outAddr, e);
		chk("outValid32", {63'h0, ov32}, 64'h1);
		chk("count32", {59'h0, cnt32}, 64'h0);
		chk("outAddr32", {32'h0, oa32}, {32'h0, a[31:0]});
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		// Whole run needs well under a thousand cycles
		if (cyc == 4000) begin
			failures++;
			tally_and_finish;
		end
	end

	initial begin
		{sys_clk, nrst, regWr, regRd, accValid, curVirt, mpv} = '0;
		{svp, xrd, hvl, hvs, exl, gb, curPriv, regAddr} = '0;
		{pp, pv, stb} = '0;
		{regWdata, accAddr} = '0;
		{failures, n_tests, cyc} = '0;
		seed = 55;
		wid = 6'h2A;
		foreach (mf[i]) mf[i] = MODE_OFF;
		repeat (5) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++) rd(i, exp_rd(i));
		rd(OFS_EFFECTIVE, 64'h100);
		for (int i = 7; i < 16; i++) begin
			wr(i, {$random(seed), $random(seed)});
			rd(i, 64'h0);
		end
		$display("test reset_map done");
		for (int i = 0; i < 5; i++)
			for (int m = 0; m < 4; m++) begin
				fw(i, m[1:0]);
				rd(i, exp_rd(i));
			end
		$display("test field_codes done");
		for (int m = 2; m < 4; m++) begin
			for (int i = 0; i < 5; i++) fw(i, m[1:0]);
			// Access straight after the writes, no fence between
			for (int j = 0; j < 17; j++)
				acc(TAB[j], j[0]);
		end
		// Last access left machine env as source with 16 bits masked
		rd(OFS_EFFECTIVE, 64'h410);
		$display("test access_select done");
		for (int k = 0; k < 3; k++) begin
			wr(OFS_WIDTH, 64'h2A ^ (64'h3 << 2*k));
			for (int i = 0; i < 5; i++) rd(i, exp_rd(i));
			for (int i = 0; i < 5; i++) fw(i, MODE_M48);
			for (int i = 0; i < 6; i++) rd(i, exp_rd(i));
			wr(OFS_WIDTH, 64'h2A);
			for (int i = 0; i < 5; i++) rd(i, exp_rd(i));
		end
		$display("test width_clear done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
